// ===== include/psc_map.svh
// Purpose: Register offsets, field positions and reset values.
// Assumes: Avalon-MM byte addressing; all twelve address bits [11:0] are decoded.
// Notes: Definitions only.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_OFS_PINSEL 12'h914
`define PSC_OFS_INTMODE 12'h930
`define PSC_OFS_MISCFEAT 12'h940
`define PSC_OFS_GPIO 12'h944
`define PSC_OFS_EVSTAT 12'h948
`define PSC_OFS_EVMASK 12'h94C
`define PSC_OFS_STATE 12'h950
`define PSC_PINSEL_RST 8'h00
`define PSC_INTMODE_RST 8'h00
`define PSC_MISCFEAT_RST 8'h00
`define PSC_EV_RST 8'h00
`define PSC_EVMASK_RST 4'h0
`define PSC_RING_BIT 7
`define PSC_PINA_LO 0
`define PSC_PINA_HI 1
`define PSC_PINB_LO 2
`define PSC_PINB_HI 3
`define PSC_MODE_LO 0
`define PSC_MODE_HI 1
`define PSC_MODE_WAY 2'h1
`define PSC_FN_INT 2'h0
`define PSC_FN_LED 2'h1
`define PSC_FN_GPIO 2'h2
`define PSC_FN_PME 2'h1
`define PSC_EV_APERR 0
`define PSC_EV_DPERR 1
`define PSC_EV_CARD 2
`define PSC_EV_RING 3
`define PSC_NEV 4
`endif

// ===== include/psc_pkg.sv
// Purpose: Types shared by the signal control block.
// Assumes: Constants live in psc_map.svh.
// Notes: No imports are used anywhere.
package psc_pkg;
	typedef struct packed
	{
		logic [31:0] ad;
		logic [3:0] cbe;
		logic par;
	} psc_bus_s;
	typedef struct packed
	{
		logic o;
		logic oe;
	} psc_pin_s;
	typedef enum logic [1:0] {PSC_IDLE, PSC_ADDR, PSC_DATA} psc_phase_e;
endpackage

// ===== core/psc_parity.sv
// Purpose: Even parity over address/data and command lines.
// Assumes: Combinational only.
// Notes: Used for both checking and generation.
`timescale 1ns/1ps
`default_nettype none
module psc_parity
(
	// Bus lines.
	input wire psc_pkg::psc_bus_s bus,
	// Results.
	output logic parGen,
	output logic parBad
);
	// The generated bit makes the ones count even over all 37 lines.
	always_comb
	begin
		parGen = ^{bus.ad, bus.cbe}; // [R2]
		parBad = parGen ^ bus.par; // [R2]
	end
endmodule
`default_nettype wire

// ===== core/psc_od_pin.sv
// Purpose: Open-drain pin driver with a registered enable.
// Assumes: Pin pulls low only while enabled.
// Notes: Output value is constant low.
`timescale 1ns/1ps
`default_nettype none
module psc_od_pin
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Request to pull low.
	input wire logic pullLow,
	// Pin.
	output psc_pkg::psc_pin_s pin
);
	// Never driven high; enable released in reset.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pin <= '{o: 1'b0, oe: 1'b0}; // [R7]
		else
			pin <= '{o: 1'b0, oe: pullLow}; // [R13]
	end
endmodule
`default_nettype wire

// ===== core/psc_signal_ctrl.sv
// Purpose: PCI-side signal control: parity, system error, request,
//	clock run and the two multiplexed interrupt pins.
// Assumes: All inputs are synchronous to clk; reset is synchronous.
// Notes: Registers reached over Avalon-MM with waitrequest.
// Functional notes
// (R1) Pulse system-error output on address parity error.
// (R2) Parity makes ones across data, command and parity even.
// (R3) Check parity the cycle after address and write data phases.
// (R4) Drive read parity from after target-ready until after completion.
// (R5) Sample bus inputs on the rising clock edge.
// (R6) Work at any clock rate up to the maximum, including stopped.
// (R7) Reset restores registers and releases every output pin.
// (R8) First pin raises interrupt for card events.
// (R9) Activity indicator on first pin only in way signalling mode.
// (R10) First pin can be general-purpose input or output.
// (R11) Second pin can be second interrupt line in plain mode.
// (R12) Feature bit 7 relays ring indicate on second pin.
// (R13) Ring and second interrupt are open-drain, pulling low only.
// (R14) Second pin can signal power-management event when selected.
// (R15) Read clock-run as status, pull low to request clock.
// (R16) Assert bus request whenever mastership is needed.
// (R17) Arbiter grant tells the device it owns the bus.
// (R18) Drive data-parity-error low on write data parity error.
// (R19) System-error pulse lasts exactly one clock.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module psc_signal_ctrl
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave.
	input wire logic [11:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [31:0] avsWriteData,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	output logic irq,
	// PCI bus inputs.
	input wire psc_pkg::psc_bus_s busIn,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic devselOwn,
	input wire logic readReturn,
	input wire logic grant_n,
	input wire logic clkRunIn_n,
	// Internal requests from the core.
	input wire logic needMaster,
	input wire logic needClock,
	input wire logic pmeNeed,
	input wire logic [7:0] cardEvents,
	input wire logic ringIndicateIn,
	input wire logic [31:0] rdAd,
	input wire logic [3:0] rdCbe,
	// PCI outputs.
	output logic parOut,
	output logic parOe,
	output logic perrOut_n,
	output logic perrOe,
	output psc_pkg::psc_pin_s serrPin,
	output logic reqOut_n,
	output logic reqOe,
	output psc_pkg::psc_pin_s clkRunPin,
	output logic busOwned,
	output logic clkRunning,
	// First interrupt pin.
	input wire logic pinAIn,
	output logic pinAOut,
	output logic pinAOe,
	// Second interrupt pin.
	output psc_pkg::psc_pin_s pinB
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] pinSel_reg;
	logic [7:0] intMode_reg;
	logic [7:0] miscFeat_reg;
	logic [7:0] gpioCtl_reg;
	logic [`PSC_NEV-1:0] evStat_reg;
	logic [`PSC_NEV-1:0] evMask_reg;
	logic [`PSC_NEV-1:0] evHit;
	logic accessDone_reg;
	psc_pkg::psc_bus_s busQ_reg;
	psc_pkg::psc_phase_e phase_reg;
	logic chkAddr_reg;
	logic chkWrite_reg;
	logic parGen;
	logic parBad;
	logic genRead;
	logic serrPull;
	logic pinBPull;
	logic ringOn;
	logic [1:0] fnA;
	logic [1:0] fnB;
	logic [1:0] intModeSel;
	logic gpioIn_reg;
	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// One wait state per access keeps read data registered.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			accessDone_reg <= 1'b0;
		else
			accessDone_reg <= (avsRead | avsWrite) & ~accessDone_reg;
	end
	assign avsWaitRequest = ~accessDone_reg;
	// Register writes take effect at the edge after the wait, while waitrequest is low.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pinSel_reg <= `PSC_PINSEL_RST; // [R7]
			intMode_reg <= `PSC_INTMODE_RST;
			miscFeat_reg <= `PSC_MISCFEAT_RST;
			gpioCtl_reg <= `PSC_MISCFEAT_RST;
			evMask_reg <= `PSC_EVMASK_RST;
		end
		else if (avsWrite && accessDone_reg)
		begin
			case (avsAddress)
				`PSC_OFS_PINSEL: pinSel_reg <= avsWriteData[7:0];
				`PSC_OFS_INTMODE: intMode_reg <= avsWriteData[7:0];
				`PSC_OFS_MISCFEAT: miscFeat_reg <= avsWriteData[7:0];
				`PSC_OFS_GPIO: gpioCtl_reg <= avsWriteData[7:0];
				`PSC_OFS_EVMASK:
					evMask_reg <= avsWriteData[`PSC_NEV-1:0];
				default: ;
			endcase
		end
	end
	// Read data is registered; unmapped addresses read zero.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			avsReadData <= 32'h00000000;
		else if (avsRead && !accessDone_reg)
		begin
			case (avsAddress)
				`PSC_OFS_PINSEL: avsReadData <= {24'h000000, pinSel_reg};
				`PSC_OFS_INTMODE: avsReadData <= {24'h000000, intMode_reg};
				`PSC_OFS_MISCFEAT:
					avsReadData <= {24'h000000, miscFeat_reg};
				`PSC_OFS_GPIO:
					avsReadData <= {23'h000000, gpioIn_reg, gpioCtl_reg};
				`PSC_OFS_EVSTAT:
					avsReadData <= {28'h0000000, evStat_reg};
				`PSC_OFS_EVMASK:
					avsReadData <= {28'h0000000, evMask_reg};
				`PSC_OFS_STATE:
					avsReadData <= {28'h0000000, clkRunning, busOwned,
						phase_reg};
				default: avsReadData <= 32'h00000000;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Parity tracking
	// ----------------------------------------------------------------
	// All bus inputs are captured on the rising edge; with no free-run
	// counters the logic is indifferent to a slow or stopped clock.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			busQ_reg <= '0;
		else
			busQ_reg <= busIn; // [R5] [R6]
	end
	// Address phase is the first frame cycle; data phases complete on
	// both ready strobes.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			phase_reg <= psc_pkg::PSC_IDLE;
			chkAddr_reg <= 1'b0;
			chkWrite_reg <= 1'b0;
		end
		else
		begin
			chkAddr_reg <= 1'b0;
			chkWrite_reg <= 1'b0;
			case (phase_reg)
				psc_pkg::PSC_IDLE:
					if (!frame_n)
					begin
						phase_reg <= psc_pkg::PSC_DATA;
						chkAddr_reg <= 1'b1; // [R3]
					end
				psc_pkg::PSC_DATA:
				begin
					if (!irdy_n && !trdy_n && devselOwn && !readReturn)
						chkWrite_reg <= 1'b1; // [R3]
					if (frame_n && !irdy_n && !trdy_n)
						phase_reg <= psc_pkg::PSC_IDLE;
					else if (frame_n && irdy_n)
						phase_reg <= psc_pkg::PSC_IDLE;
				end
				default: phase_reg <= psc_pkg::PSC_IDLE;
			endcase
		end
	end
	// Parity of the phase captured one cycle earlier, checked now.
	psc_parity u_chk
	(
		.bus(psc_pkg::psc_bus_s'{ad: busQ_reg.ad, cbe: busQ_reg.cbe,
			par: busIn.par}),
		.parGen(),
		.parBad(parBad)
	);
	// Generator for the data the device returns on reads.
	psc_parity u_gen
	(
		.bus(psc_pkg::psc_bus_s'{ad: rdAd, cbe: rdCbe, par: 1'b0}),
		.parGen(parGen),
		.parBad()
	);
	// Read parity follows target-ready by one cycle and ends one cycle
	// after the phase completes.
	assign genRead = readReturn && devselOwn && !trdy_n;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			parOut <= 1'b0;
			parOe <= 1'b0; // [R7]
		end
		else
		begin
			parOut <= parGen; // [R2] [R4]
			parOe <= genRead; // [R4]
		end
	end
	// ----------------------------------------------------------------
	// Error signalling
	// ----------------------------------------------------------------
	assign serrPull = chkAddr_reg && parBad && !serrPin.oe; // [R1] [R19]
	psc_od_pin u_serr
	(
		.clk(clk),
		.rst_n(rst_n),
		.pullLow(serrPull),
		.pin(serrPin)
	);
	// Data parity error driven low for the cycle after detection.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			perrOut_n <= 1'b1;
			perrOe <= 1'b0;
		end
		else
		begin
			perrOut_n <= ~(chkWrite_reg && parBad); // [R18]
			perrOe <= chkWrite_reg;
		end
	end
	// ----------------------------------------------------------------
	// Arbitration and clock run
	// ----------------------------------------------------------------
	// Request follows need; grant is trusted to mark ownership.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			reqOut_n <= 1'b1;
			reqOe <= 1'b0;
			busOwned <= 1'b0;
			clkRunning <= 1'b0;
		end
		else
		begin
			reqOut_n <= ~needMaster; // [R16]
			reqOe <= 1'b1;
			busOwned <= ~grant_n & needMaster; // [R17]
			clkRunning <= ~clkRunIn_n; // [R15]
		end
	end
	// Pull clock-run low only when the clock is reported stopping.
	psc_od_pin u_clkrun
	(
		.clk(clk),
		.rst_n(rst_n),
		.pullLow(needClock && clkRunIn_n), // [R15]
		.pin(clkRunPin)
	);
	// ----------------------------------------------------------------
	// Event status and interrupt
	// ----------------------------------------------------------------
	assign evHit = {ringIndicateIn, |cardEvents, chkWrite_reg & parBad,
		chkAddr_reg & parBad};
	// Sticky bits; a new event wins over a write-one clear.
	genvar gi;
	generate
		for (gi = 0; gi < `PSC_NEV; gi++)
		begin : g_ev
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					evStat_reg[gi] <= 1'b0;
				else if (evHit[gi])
					evStat_reg[gi] <= 1'b1;
				else if (avsWrite && accessDone_reg &&
					avsAddress == `PSC_OFS_EVSTAT && avsWriteData[gi])
					evStat_reg[gi] <= 1'b0;
			end
		end
	endgenerate
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(evStat_reg & evMask_reg);
	end
	// ----------------------------------------------------------------
	// Interrupt pin multiplexing
	// ----------------------------------------------------------------
	assign fnA = pinSel_reg[`PSC_PINA_HI:`PSC_PINA_LO];
	assign fnB = pinSel_reg[`PSC_PINB_HI:`PSC_PINB_LO];
	assign intModeSel = intMode_reg[`PSC_MODE_HI:`PSC_MODE_LO];
	assign ringOn = miscFeat_reg[`PSC_RING_BIT];
	// First pin: interrupt, activity light in way mode only, or GPIO.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pinAOut <= 1'b0;
			pinAOe <= 1'b0; // [R7]
			gpioIn_reg <= 1'b0;
		end
		else
		begin
			gpioIn_reg <= pinAIn; // [R10]
			case (fnA)
				`PSC_FN_INT:
				begin
					pinAOut <= 1'b0;
					pinAOe <= |cardEvents; // [R8]
				end
				`PSC_FN_LED:
				begin
					pinAOut <= 1'b0;
					pinAOe <= (intModeSel == `PSC_MODE_WAY) &&
						|cardEvents; // [R9]
				end
				`PSC_FN_GPIO:
				begin
					pinAOut <= gpioCtl_reg[0]; // [R10]
					pinAOe <= gpioCtl_reg[1];
				end
				default:
				begin
					pinAOut <= 1'b0;
					pinAOe <= 1'b0;
				end
			endcase
		end
	end
	// Second pin: ring relay overrides; else wake event or interrupt.
	always_comb
	begin
		if (ringOn)
			pinBPull = ringIndicateIn; // [R12]
		else if (fnB == `PSC_FN_PME)
			pinBPull = pmeNeed; // [R14]
		else if (fnB == `PSC_FN_INT && intModeSel != `PSC_MODE_WAY)
			pinBPull = |(evStat_reg & evMask_reg); // [R11]
		else
			pinBPull = 1'b0;
	end
	psc_od_pin u_pinb
	(
		.clk(clk),
		.rst_n(rst_n),
		.pullLow(pinBPull), // [R13]
		.pin(pinB)
	);
endmodule
`default_nettype wire

// ===== verification/psc_signal_ctrl_checker.sv
// Purpose: Port-level assertions for the signal control block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Latency windows allow for one register stage of slack.
`timescale 1ns/1ps
`default_nettype none
module psc_signal_ctrl_checker
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Register bus.
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic avsWaitRequest,
	// Bus inputs.
	input wire psc_pkg::psc_bus_s busIn,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic trdy_n,
	input wire logic devselOwn,
	input wire logic readReturn,
	input wire logic needMaster,
	input wire logic [31:0] rdAd,
	input wire logic [3:0] rdCbe,
	// Outputs.
	input wire logic parOut,
	input wire logic parOe,
	input wire logic perrOut_n,
	input wire logic perrOe,
	input wire psc_pkg::psc_pin_s serrPin,
	input wire logic reqOut_n,
	input wire logic reqOe,
	input wire psc_pkg::psc_pin_s clkRunPin,
	input wire logic pinAOe,
	input wire psc_pkg::psc_pin_s pinB
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Bad address parity must give a pulse within two cycles.
	property p_serr;
		$fell(frame_n) ##1 (^{$past(busIn.ad), $past(busIn.cbe)} != busIn.par)
		|-> ##[1:2] serrPin.oe;
	endproperty
	a_serr: assert property (p_serr)
		else $error("serr missing");
	property p_serr_one;
		serrPin.oe |-> !serrPin.o ##1 !serrPin.oe;
	endproperty
	a_serr_one: assert property (p_serr_one)
		else $error("serr length");
	property p_perr;
		(!irdy_n && !trdy_n && devselOwn && !readReturn) ##1
		(^{$past(busIn.ad), $past(busIn.cbe)} != busIn.par)
		|-> ##[1:2] (perrOe && !perrOut_n);
	endproperty
	a_perr: assert property (p_perr)
		else $error("perr missing");
	property p_par_rd;
		(readReturn && devselOwn && !trdy_n)
		|-> ##[1:2] (parOe && parOut == ^{rdAd, rdCbe});
	endproperty
	a_par_rd: assert property (p_par_rd)
		else $error("read parity");
	// Reset must release the pins by the next edge, so this one is not disabled by it.
	property p_reset;
		disable iff (1'b0) !rst_n |=> !(parOe || perrOe || serrPin.oe
		|| reqOe || clkRunPin.oe || pinAOe || pinB.oe);
	endproperty
	a_reset: assert property (p_reset)
		else $error("pin driven in reset");
	property p_od;
		!(pinB.oe && pinB.o) && !(clkRunPin.oe && clkRunPin.o);
	endproperty
	a_od: assert property (p_od)
		else $error("open drain driven high");
	property p_req;
		needMaster |=> reqOe && !reqOut_n;
	endproperty
	a_req: assert property (p_req)
		else $error("request missing");
	property p_wait;
		(avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
	endproperty
	a_wait: assert property (p_wait)
		else $error("bus answer late");
endmodule
bind psc_signal_ctrl psc_signal_ctrl_checker chk_u
(
	.clk, .rst_n, .avsRead, .avsWrite, .avsWaitRequest, .busIn,
	.frame_n, .irdy_n, .trdy_n, .devselOwn, .readReturn, .needMaster,
	.rdAd, .rdCbe, .parOut, .parOe, .perrOut_n, .perrOe, .serrPin,
	.reqOut_n, .reqOe, .clkRunPin, .pinAOe, .pinB
);
`default_nettype wire

// ===== verification/psc_host_model.sv
// Purpose: Host bridge, arbiter and clock-run pull-up of the bus.
// Assumes: Signals change by non-blocking assignment after an edge.
// Notes: Released lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module psc_host_model
(
	// Clock.
	input wire logic clk,
	// Device outputs.
	input wire logic reqOut_n,
	input wire logic reqOe,
	input wire psc_pkg::psc_pin_s clkRunPin,
	// Host-driven lines.
	output psc_pkg::psc_bus_s busIn,
	output logic frame_n,
	output logic irdy_n,
	output logic trdy_n,
	output logic grant_n,
	output logic clkRunIn_n
);
	// The pull-up wins unless the device pulls the line low.
	assign clkRunIn_n = !clkRunPin.oe;
	initial
	begin
		busIn = '0;
		frame_n = 1'b1;
		irdy_n = 1'b1;
		trdy_n = 1'b1;
		grant_n = 1'b1;
	end
	// Grant follows a driven request one cycle later.
	always @(posedge clk)
		grant_n <= !(reqOe && !reqOut_n);
	// Address phase then one write data phase with the same word.
	task automatic cyc(input logic [31:0] ad, input logic [3:0] cbe,
		input logic [1:0] bad);
		@(posedge clk);
		frame_n <= 1'b0;
		busIn <= {ad, cbe, ~busIn.par};
		@(posedge clk);
		frame_n <= 1'b1;
		irdy_n <= 1'b0;
		trdy_n <= 1'b0;
		busIn.par <= ^{ad, cbe} ^ bad[0];
		@(posedge clk);
		irdy_n <= 1'b1;
		trdy_n <= 1'b1;
		busIn.par <= ^{ad, cbe} ^ bad[1];
		@(posedge clk);
		busIn <= ~busIn;
	endtask
	// One target-ready cycle for a read.
	task automatic rd();
		@(posedge clk);
		trdy_n <= 1'b0;
		@(posedge clk);
		trdy_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_pci_side_signal_control.sv
// Purpose: Self-checking bench for the signal control block.
// Assumes: One wait state per register access.
// Notes: Pin waits allow up to eight clock cycles before failing.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module tb_pci_side_signal_control;
	logic clk, rst_n, avsRead, avsWrite, avsWaitRequest, irq;
	logic [11:0] avsAddress;
	logic [31:0] avsWriteData, avsReadData, rdAd, q;
	logic frame_n, irdy_n, trdy_n, devselOwn, readReturn, grant_n;
	logic clkRunIn_n, needMaster, ringIndicateIn, pinAIn, parOut, parOe;
	logic perrOut_n, perrOe, reqOut_n, reqOe, busOwned, pinAOut, pinAOe;
	logic [7:0] cardEvents;
	logic needClock, pmeNeed;
	logic [3:0] rdCbe;
	psc_pkg::psc_bus_s busIn;
	psc_pkg::psc_pin_s serrPin, clkRunPin, pinB;
	int err_total, n_checks;
	typedef struct packed {logic [11:0] a; logic [31:0] d, e;} psc_row_s;
	psc_row_s rows[5];

	psc_signal_ctrl dut_u
	(
		.clk, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
		.avsReadData, .avsWaitRequest, .irq, .busIn, .frame_n, .irdy_n,
		.trdy_n, .devselOwn, .readReturn, .grant_n, .clkRunIn_n,
		.needMaster, .needClock, .pmeNeed, .cardEvents,
		.ringIndicateIn, .rdAd, .rdCbe, .parOut, .parOe, .perrOut_n,
		.perrOe, .serrPin, .reqOut_n, .reqOe, .clkRunPin, .busOwned,
		.clkRunning(), .pinAIn, .pinAOut, .pinAOe, .pinB
	);
	psc_host_model host_u
	(
		.clk, .reqOut_n, .reqOe, .clkRunPin, .busIn, .frame_n, .irdy_n,
		.trdy_n, .grant_n, .clkRunIn_n
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// Bus cycle: request held until waitrequest is seen low.
	task automatic av(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		avsAddress <= a;
		avsWrite <= w;
		avsRead <= !w;
		avsWriteData <= d;
		for (k = 0; k < 20 && avsWaitRequest !== 1'b0; k++)
			@(posedge clk);
		if (k == 20)
		begin
			chk("waitrequest", 0, 1);
			end_of_test();
		end
		q = avsReadData;
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	// Bounded wait for one of the watched pin enables or bus ownership.
	task automatic waitOn(input int s);
		int k;
		logic [4:0] v;
		for (k = 0; k < 8; k++)
		begin
			#1;
			v = {pinB.oe, busOwned, parOe, perrOe, serrPin.oe};
			if (v[s] === 1'b1)
				break;
			@(posedge clk);
		end
		if (k == 8)
		begin
			chk("wait", s, 99);
			end_of_test();
		end
	endtask

	initial
	begin
		{rst_n, avsRead, avsWrite, avsAddress, avsWriteData} = '0;
		{devselOwn, readReturn, needMaster, ringIndicateIn, pinAIn} = '0;
		{cardEvents, rdAd, rdCbe, needClock, pmeNeed} = '0;
		rows[0] = {12'h914, 32'hFF, 32'hFF};
		rows[1] = {12'h930, 32'hFF, 32'hFF};
		rows[2] = {12'h940, 32'h80, 32'h80};
		rows[3] = {12'h94C, 32'h0F, 32'h0F};
		rows[4] = {12'h000, 32'hFF, 32'h00};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[j])
		begin
			av(0, rows[j].a, 0);
			chk("reset value", 0, q);
			av(1, rows[j].a, rows[j].d);
			av(0, rows[j].a, 0);
			chk("readback", rows[j].e, q);
		end
		av(1, `PSC_OFS_PINSEL, 0);
		av(1, `PSC_OFS_INTMODE, 0);
		av(1, `PSC_OFS_MISCFEAT, 0);
		// Address parity error: one-cycle pulse, sticky status, interrupt.
		// The pulse lasts one cycle, so watch for it while the cycle runs.
		fork
			host_u.cyc(32'h0000_0003, 4'h6, 2'b01);
			waitOn(0);
		join
		@(posedge clk);
		#1;
		chk("serr pulse", 0, serrPin.oe);
		av(0, `PSC_OFS_EVSTAT, 0);
		chk("addr status", 1, q[0]);
		chk("irq", 1, irq);
		av(1, `PSC_OFS_EVSTAT, 32'h1);
		av(0, `PSC_OFS_EVSTAT, 0);
		chk("cleared", 0, {q[0], irq});
		// Card event while masked, then unmasked.
		av(1, `PSC_OFS_EVMASK, 0);
		cardEvents <= 8'h01;
		av(0, `PSC_OFS_EVSTAT, 0);
		cardEvents <= 8'h00;
		chk("masked", 2'b10, {q[2], irq});
		av(1, `PSC_OFS_EVMASK, 32'h4);
		av(0, `PSC_OFS_EVMASK, 0);
		chk("unmasked irq", 1, irq);
		// Write data parity error.
		devselOwn <= 1'b1;
		host_u.cyc(32'hF0F0_0001, 4'h0, 2'b10);
		waitOn(1);
		chk("perr level", 0, perrOut_n);
		// Read parity generation.
		@(posedge clk);
		readReturn <= 1'b1;
		rdAd <= 32'hA5A5_0001;
		host_u.rd();
		waitOn(2);
		chk("read parity", 1, parOut);
		@(posedge clk);
		readReturn <= 1'b0;
		// First pin as general-purpose output and input.
		av(1, `PSC_OFS_PINSEL, `PSC_FN_GPIO);
		av(1, `PSC_OFS_GPIO, 32'h3);
		pinAIn <= 1'b1;
		av(0, `PSC_OFS_GPIO, 0);
		chk("gpio", 3'b111, {q[8], pinAOe, pinAOut});
		// Ring relay in plain and way modes.
		av(1, `PSC_OFS_PINSEL, 0);
		av(1, `PSC_OFS_MISCFEAT, 32'h80);
		ringIndicateIn <= 1'b1;
		waitOn(4);
		av(1, `PSC_OFS_INTMODE, `PSC_MODE_WAY);
		#1;
		chk("ring way", 2'b10, {pinB.oe, pinB.o});
		// Request and grant.
		@(posedge clk);
		needMaster <= 1'b1;
		waitOn(3);
		// Clock-run pull while the line reads as stopped.
		@(posedge clk);
		needClock <= 1'b1;
		@(posedge clk);
		#1;
		chk("clock run pull", 2'b10, {clkRunPin.oe, clkRunPin.o});
		@(posedge clk);
		needClock <= 1'b0;
		// Reset in mid-run releases every pin.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("pins in reset", 0, {parOe, perrOe, serrPin.oe, reqOe,
			clkRunPin.oe, pinAOe, pinB.oe, !avsWaitRequest});
		@(posedge clk);
		rst_n <= 1'b1;
		av(0, `PSC_OFS_MISCFEAT, 0);
		chk("reset again", 0, q);
		// Second pin as power-management event output.
		ringIndicateIn <= 1'b0;
		av(1, `PSC_OFS_PINSEL, 32'h4);
		pmeNeed <= 1'b1;
		waitOn(4);
		chk("wake pin low", 0, pinB.o);
		end_of_test();
	end
endmodule
`default_nettype wire
